// ===== cra_consts.vh
`ifndef CRA_CONSTS_VH
`define CRA_CONSTS_VH
// ==========================================================
// Register offsets
`define CRA_OFF_ACCD    8'h00
`define CRA_OFF_ACCA    8'h04
`define CRA_OFF_ACCB    8'h08
`define CRA_OFF_IDXX    8'h0c
`define CRA_OFF_IDXY    8'h10
`define CRA_OFF_STACK   8'h14
`define CRA_OFF_PC      8'h18
`define CRA_OFF_CCR     8'h1c
`define CRA_OFF_CMD     8'h20
`define CRA_OFF_STATUS  8'h24
`define CRA_OFF_EA      8'h28
`define CRA_OFF_QUEUE   8'h2c
// ==========================================================
// Condition code bits and reset value
`define CRA_CC_S        7
`define CRA_CC_X        6
`define CRA_CC_H        5
`define CRA_CC_I        4
`define CRA_CC_N        3
`define CRA_CC_Z        2
`define CRA_CC_V        1
`define CRA_CC_C        0
`define CRA_CCR_RESET   8'hd0
// ==========================================================
// Commands, modes and arithmetic operations
`define CRA_CMD_FETCH   3'h1
`define CRA_CMD_EA      3'h2
`define CRA_CMD_ALU     3'h3
`define CRA_CMD_CALL    3'h4
`define CRA_CMD_STOP    3'h5
`define CRA_MODE_INH    4'h0
`define CRA_MODE_IMM    4'h1
`define CRA_MODE_DIR    4'h2
`define CRA_MODE_EXT    4'h3
`define CRA_MODE_REL8   4'h4
`define CRA_MODE_REL16  4'h5
`define CRA_MODE_IDX    4'h6
`define CRA_ALU_ABA     4'h0
`define CRA_ALU_ADD     4'h1
`define CRA_ALU_ADC     4'h2
`define CRA_ALU_SUB     4'h3
`define CRA_ALU_LOAD    4'h4
// ==========================================================
// Fetch and addressing constants
`define CRA_PREFIX_PAGE2 8'h18
`define CRA_QDEPTH      3'h4
`define CRA_QLAST       3'h3
`define CRA_RR_X        2'h0
`define CRA_RR_Y        2'h1
`define CRA_RR_SP       2'h2
`define CRA_RR_PC       2'h3
`define CRA_ONE16       16'h0001
`define CRA_TWO16       16'h0002
`endif

// ===== cra_core.v
`timescale 1ns/100ps
`include "cra_consts.vh"
module cra_core (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         mem_req,
  output reg         mem_we,
  output reg  [15:0] mem_addr,
  output reg  [7:0]  mem_wdata,
  input  wire [7:0]  mem_rdata,
  input  wire        mem_ack,
  input  wire        irq_req,
  input  wire        high_priority_irq_pin,
  output reg         irq_accept,
  output reg         high_priority_irq_accept,
  output reg         stopped
);

  // ==========================================================
  // States
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_DECODE = 3'h1;
  localparam [2:0] ST_FETCH  = 3'h2;
  localparam [2:0] ST_INDHI  = 3'h3;
  localparam [2:0] ST_INDLO  = 3'h4;
  localparam [2:0] ST_PUSHHI = 3'h5;
  localparam [2:0] ST_PUSHLO = 3'h6;

  reg  [7:0]  acca_reg;
  reg  [7:0]  accb_reg;
  reg  [15:0] idxx_reg;
  reg  [15:0] idxy_reg;
  reg  [15:0] stack_reg;
  reg  [15:0] pc_reg;
  reg  [7:0]  ccr_reg;
  reg  [2:0]  state_reg;
  reg  [2:0]  cmd_reg;
  reg  [3:0]  mode_reg;
  reg  [7:0]  opnd_reg;
  reg  [2:0]  qcnt_reg;
  reg         page2_reg;
  reg         err_reg;
  reg  [15:0] fa_reg;
  reg  [15:0] ea_reg;
  reg  [7:0]  ptr_hi_reg;
  reg  [7:0]  q_reg [0:3];

  // ==========================================================
  // Functions
  function [15:0] base_sel;
    input [1:0]  rr;
    input [15:0] x;
    input [15:0] y;
    input [15:0] s;
    input [15:0] p;
    begin
      case (rr)
        `CRA_RR_X:  base_sel = x;
        `CRA_RR_Y:  base_sel = y;
        `CRA_RR_SP: base_sel = s;
        default:    base_sel = p;
      endcase
    end
  endfunction

  function [15:0] sext8;
    input [7:0] b;
    begin
      sext8 = {{8{b[7]}}, b};
    end
  endfunction

  // ==========================================================
  // Effective address decode
  wire [7:0]  pb  = q_reg[1];
  wire [7:0]  e1  = q_reg[2];
  wire [7:0]  e2  = q_reg[3];
  wire [15:0] acc_d = {acca_reg, accb_reg};
  reg  [15:0] ea_w;
  reg  [15:0] upd_w;
  reg  [1:0]  rr_w;
  reg         ind_w;
  reg         upd_en_w;
  reg         bad_w;
  reg  [15:0] base_w;
  reg  [15:0] off_w;

  always @* begin
    ea_w     = 16'h0000;
    upd_w    = 16'h0000;
    rr_w     = pb[7:6];
    ind_w    = 1'b0;
    upd_en_w = 1'b0;
    bad_w    = 1'b0;
    off_w    = 16'h0000;
    base_w   = 16'h0000;
    case (mode_reg)
      `CRA_MODE_INH:   ea_w = pc_reg;
      `CRA_MODE_IMM:   ea_w = pc_reg + `CRA_ONE16;
      `CRA_MODE_DIR:   ea_w = {8'h00, pb};
      `CRA_MODE_EXT:   ea_w = {pb, e1};
      `CRA_MODE_REL8:  ea_w = pc_reg + sext8(pb);
      `CRA_MODE_REL16: ea_w = pc_reg + {pb, e1};
      `CRA_MODE_IDX: begin
        if (pb[7:5] == 3'h7) begin
          rr_w   = pb[4:3];
          base_w = base_sel(rr_w, idxx_reg, idxy_reg, stack_reg,
                            pc_reg);
          if (!pb[2]) begin
            if (!pb[1])
              off_w = {{7{pb[0]}}, pb[0], e1};
            else
              off_w = {e1, e2};
            ind_w = pb[1] & pb[0];
          end else begin
            case (pb[1:0])
              2'h0:    off_w = {8'h00, acca_reg};
              2'h1:    off_w = {8'h00, accb_reg};
              default: off_w = acc_d;
            endcase
            ind_w = pb[1] & pb[0];
          end
          ea_w = base_w + off_w;
        end else if (!pb[5]) begin
          base_w = base_sel(rr_w, idxx_reg, idxy_reg, stack_reg,
                            pc_reg);
          off_w  = {{11{pb[4]}}, pb[4:0]};
          ea_w   = base_w + off_w;
        end else begin
          // The pc has no write path here, so it is refused as base.
          bad_w    = (rr_w == `CRA_RR_PC);
          base_w   = base_sel(rr_w, idxx_reg, idxy_reg, stack_reg,
                              pc_reg);
          off_w    = {{12{pb[3]}}, pb[3:0]} +
                     (pb[3] ? 16'h0000 : `CRA_ONE16);
          upd_w    = base_w + off_w;
          upd_en_w = ~bad_w;
          ea_w     = pb[4] ? base_w : upd_w;
        end
      end
      default: bad_w = 1'b1;
    endcase
  end

  // ==========================================================
  // Arithmetic and flags
  wire [4:0] half_sum;
  wire [8:0] full_sum;
  wire [8:0] full_dif;
  reg  [7:0] alu_b;
  reg        alu_cin;

  always @* begin
    alu_b   = opnd_reg;
    alu_cin = 1'b0;
    case (mode_reg)
      `CRA_ALU_ABA: alu_b   = accb_reg;
      `CRA_ALU_ADC: alu_cin = ccr_reg[`CRA_CC_C];
      default:      alu_cin = 1'b0;
    endcase
  end

  assign half_sum = {1'b0, acca_reg[3:0]} + {1'b0, alu_b[3:0]} +
                    {4'h0, alu_cin};
  assign full_sum = {1'b0, acca_reg} + {1'b0, alu_b} +
                    {8'h00, alu_cin};
  assign full_dif = {1'b0, acca_reg} - {1'b0, alu_b};

  reg [7:0] res_w;
  reg [7:0] ccr_alu_w;
  reg       alu_ok_w;

  always @* begin
    res_w     = full_sum[7:0];
    ccr_alu_w = ccr_reg;
    alu_ok_w  = 1'b1;
    case (mode_reg)
      `CRA_ALU_ABA, `CRA_ALU_ADD, `CRA_ALU_ADC: begin
        ccr_alu_w[`CRA_CC_H] = half_sum[4];
        ccr_alu_w[`CRA_CC_C] = full_sum[8];
        ccr_alu_w[`CRA_CC_V] = (acca_reg[7] & alu_b[7] & ~res_w[7]) |
                               (~acca_reg[7] & ~alu_b[7] & res_w[7]);
      end
      `CRA_ALU_SUB: begin
        res_w = full_dif[7:0];
        ccr_alu_w[`CRA_CC_C] = full_dif[8];
        ccr_alu_w[`CRA_CC_V] = (acca_reg[7] & ~alu_b[7] & ~res_w[7]) |
                               (~acca_reg[7] & alu_b[7] & res_w[7]);
      end
      `CRA_ALU_LOAD: begin
        res_w = opnd_reg;
        ccr_alu_w[`CRA_CC_V] = 1'b0;
      end
      default: alu_ok_w = 1'b0;
    endcase
    if (alu_ok_w) begin
      ccr_alu_w[`CRA_CC_N] = res_w[7];
      ccr_alu_w[`CRA_CC_Z] = (res_w == 8'h00);
    end else begin
      ccr_alu_w = ccr_reg;
    end
  end

  // ==========================================================
  // APB slave
  wire setup    = psel & ~penable;
  wire busy     = (state_reg != ST_IDLE);
  wire sel_ok   = (paddr == `CRA_OFF_ACCD)   | (paddr == `CRA_OFF_ACCA) |
                  (paddr == `CRA_OFF_ACCB)   | (paddr == `CRA_OFF_IDXX) |
                  (paddr == `CRA_OFF_IDXY)   | (paddr == `CRA_OFF_STACK) |
                  (paddr == `CRA_OFF_PC)     | (paddr == `CRA_OFF_CCR) |
                  (paddr == `CRA_OFF_CMD)    | (paddr == `CRA_OFF_STATUS) |
                  (paddr == `CRA_OFF_EA)     | (paddr == `CRA_OFF_QUEUE);
  wire wr_fire  = psel & penable & pready & pwrite & ~pslverr;
  reg  [31:0] rd_mux;

  function wr_hit;
    input [7:0] a;
    input [7:0] off;
    begin
      wr_hit = (a == off);
    end
  endfunction

  always @* begin
    case (paddr)
      `CRA_OFF_ACCD:   rd_mux = {16'h0000, acc_d};
      `CRA_OFF_ACCA:   rd_mux = {24'h000000, acca_reg};
      `CRA_OFF_ACCB:   rd_mux = {24'h000000, accb_reg};
      `CRA_OFF_IDXX:   rd_mux = {16'h0000, idxx_reg};
      `CRA_OFF_IDXY:   rd_mux = {16'h0000, idxy_reg};
      `CRA_OFF_STACK:  rd_mux = {16'h0000, stack_reg};
      `CRA_OFF_PC:     rd_mux = {16'h0000, pc_reg};
      `CRA_OFF_CCR:    rd_mux = {24'h000000, ccr_reg};
      `CRA_OFF_STATUS: rd_mux = {16'h0000, q_reg[0], stopped, page2_reg,
                                 err_reg, busy, 1'b0, qcnt_reg};
      `CRA_OFF_EA:     rd_mux = {16'h0000, ea_reg};
      `CRA_OFF_QUEUE:  rd_mux = {q_reg[0], q_reg[1], q_reg[2], q_reg[3]};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // Writes during a running command are refused so the engine
  // and software never both update the same register.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & (~sel_ok | (pwrite & busy));
      prdata  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ==========================================================
  // Prefetch queue
  wire prefix_skip = (qcnt_reg == 3'h0) & ~page2_reg &
                     (mem_rdata == `CRA_PREFIX_PAGE2);
  wire q_load      = (state_reg == ST_FETCH) & mem_ack & ~prefix_skip;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_queue
      always @(posedge pclk) begin
        if (q_load && (qcnt_reg == gi))
          q_reg[gi] <= mem_rdata;
      end
    end
  endgenerate

  // ==========================================================
  // Programming model data registers, unaffected by reset
  wire cmd_wr = wr_fire & wr_hit(paddr, `CRA_OFF_CMD);
  wire do_ea  = (state_reg == ST_DECODE) & (cmd_reg == `CRA_CMD_EA) &
                ~bad_w;
  wire do_alu = (state_reg == ST_DECODE) & (cmd_reg == `CRA_CMD_ALU) &
                alu_ok_w;

  always @(posedge pclk) begin
    if (wr_fire && wr_hit(paddr, `CRA_OFF_ACCD))
      {acca_reg, accb_reg} <= pwdata[15:0];
    if (wr_fire && wr_hit(paddr, `CRA_OFF_ACCA))
      acca_reg <= pwdata[7:0];
    if (wr_fire && wr_hit(paddr, `CRA_OFF_ACCB))
      accb_reg <= pwdata[7:0];
    if (do_alu)
      acca_reg <= res_w;
    if (wr_fire && wr_hit(paddr, `CRA_OFF_IDXX))
      idxx_reg <= pwdata[15:0];
    if (wr_fire && wr_hit(paddr, `CRA_OFF_IDXY))
      idxy_reg <= pwdata[15:0];
    if (wr_fire && wr_hit(paddr, `CRA_OFF_STACK))
      stack_reg <= pwdata[15:0];
    if (wr_fire && wr_hit(paddr, `CRA_OFF_PC))
      pc_reg <= pwdata[15:0];
    if (do_ea && upd_en_w) begin
      case (rr_w)
        `CRA_RR_X: idxx_reg  <= upd_w;
        `CRA_RR_Y: idxy_reg  <= upd_w;
        default:   stack_reg <= upd_w;
      endcase
    end
    if ((state_reg == ST_DECODE) && (cmd_reg == `CRA_CMD_CALL))
      stack_reg <= stack_reg - `CRA_TWO16;
    if ((state_reg == ST_PUSHLO) && mem_ack)
      pc_reg <= ea_reg;
  end

  // ==========================================================
  // Command engine and memory port
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= ST_IDLE;
      cmd_reg    <= 3'h0;
      mode_reg   <= 4'h0;
      opnd_reg   <= 8'h00;
      qcnt_reg   <= 3'h0;
      page2_reg  <= 1'b0;
      err_reg    <= 1'b0;
      fa_reg     <= 16'h0000;
      ea_reg     <= 16'h0000;
      ptr_hi_reg <= 8'h00;
      ccr_reg    <= `CRA_CCR_RESET;
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= 16'h0000;
      mem_wdata  <= 8'h00;
      stopped    <= 1'b0;
      irq_accept <= 1'b0;
      high_priority_irq_accept <= 1'b0;
    end else begin
      irq_accept <= irq_req & ~ccr_reg[`CRA_CC_I];
      high_priority_irq_accept <= high_priority_irq_pin &
                                  ~ccr_reg[`CRA_CC_X];
      if ((irq_req & ~ccr_reg[`CRA_CC_I]) |
          (high_priority_irq_pin & ~ccr_reg[`CRA_CC_X]))
        stopped <= 1'b0;
      if (wr_fire && wr_hit(paddr, `CRA_OFF_CCR))
        ccr_reg <= pwdata[7:0];
      if (mem_ack)
        mem_req <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (cmd_wr) begin
            cmd_reg   <= pwdata[2:0];
            mode_reg  <= pwdata[7:4];
            opnd_reg  <= pwdata[15:8];
            err_reg   <= 1'b0;
            state_reg <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          state_reg <= ST_IDLE;
          case (cmd_reg)
            `CRA_CMD_FETCH: begin
              // Any byte address is a legal start for code.
              fa_reg    <= pc_reg;
              qcnt_reg  <= 3'h0;
              page2_reg <= 1'b0;
              mem_req   <= 1'b1;
              mem_we    <= 1'b0;
              mem_addr  <= pc_reg;
              state_reg <= ST_FETCH;
            end
            `CRA_CMD_EA: begin
              if (bad_w) begin
                err_reg <= 1'b1;
              end else begin
                ea_reg <= ea_w;
                if (ind_w) begin
                  mem_req   <= 1'b1;
                  mem_we    <= 1'b0;
                  mem_addr  <= ea_w;
                  state_reg <= ST_INDHI;
                end
              end
            end
            `CRA_CMD_ALU: begin
              if (alu_ok_w)
                ccr_reg <= ccr_alu_w;
              else
                err_reg <= 1'b1;
            end
            `CRA_CMD_CALL: begin
              mem_req   <= 1'b1;
              mem_we    <= 1'b1;
              mem_addr  <= stack_reg - `CRA_TWO16;
              mem_wdata <= pc_reg[15:8];
              state_reg <= ST_PUSHHI;
            end
            `CRA_CMD_STOP: begin
              if (!ccr_reg[`CRA_CC_S])
                stopped <= 1'b1;
            end
            default: err_reg <= 1'b1;
          endcase
        end
        ST_FETCH: begin
          if (mem_ack) begin
            if (prefix_skip)
              page2_reg <= 1'b1;
            else
              qcnt_reg <= qcnt_reg + 3'h1;
            fa_reg <= fa_reg + `CRA_ONE16;
            // The queue fills past three bytes so the extension of
            // a long indexed form is also at hand.
            if (!prefix_skip && (qcnt_reg == `CRA_QLAST)) begin
              state_reg <= ST_IDLE;
            end else begin
              mem_req  <= 1'b1;
              mem_addr <= fa_reg + `CRA_ONE16;
            end
          end
        end
        ST_INDHI: begin
          if (mem_ack) begin
            ptr_hi_reg <= mem_rdata;
            mem_req    <= 1'b1;
            mem_addr   <= ea_reg + `CRA_ONE16;
            state_reg  <= ST_INDLO;
          end
        end
        ST_INDLO: begin
          if (mem_ack) begin
            ea_reg    <= {ptr_hi_reg, mem_rdata};
            state_reg <= ST_IDLE;
          end
        end
        ST_PUSHHI: begin
          if (mem_ack) begin
            mem_req   <= 1'b1;
            mem_addr  <= stack_reg + `CRA_ONE16;
            mem_wdata <= pc_reg[7:0];
            state_reg <= ST_PUSHLO;
          end
        end
        ST_PUSHLO: begin
          if (mem_ack) begin
            mem_we    <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// ===== cra_core_sva.sv
`timescale 1ns/100ps
// ====
// Port checks of the core.
module cra_core_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic        irq_req,
  input wire logic        high_priority_irq_pin,
  input wire logic        irq_accept,
  input wire logic        high_priority_irq_accept
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence wait_s; mem_req && !mem_ack; endsequence
  a_ready_setup: assert property (setup_s |=> pready)
    else $error("ready late");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not cleared");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_mem_hold: assert property (wait_s |=> mem_req &&
    $stable(mem_addr)) else $error("memory request moved");
  a_irq_gate: assert property (irq_accept |-> $past(irq_req))
    else $error("accept without request");
  a_hp_gate: assert property (high_priority_irq_accept |->
    $past(high_priority_irq_pin)) else $error("accept without pin");
endmodule
bind cra_core cra_core_sva u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr),
  .mem_ack(mem_ack), .irq_req(irq_req),
  .high_priority_irq_pin(high_priority_irq_pin),
  .irq_accept(irq_accept),
  .high_priority_irq_accept(high_priority_irq_accept));

// ===== cra_mem_model.sv
`timescale 1ns/100ps
// ====
// Byte memory behind the core, with a chosen wait per access.
module cra_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic [1:0]  lat,
  output logic      [7:0]  mem_rdata,
  output logic             mem_ack
);
  logic [7:0] mem [0:65535];
  logic [1:0] cnt;
  wire        go = mem_req && !mem_ack && cnt == lat;
  // Data toggles off the ack edge so a late sample never matches.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= 8'h00;
    end else begin
      mem_ack <= go;
      cnt <= (mem_req && !mem_ack && !go) ? cnt + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
      if (go && mem_we)
        mem[mem_addr] <= mem_wdata;
      if (go && !mem_we)
        mem_rdata <= mem[mem_addr];
    end
  end
endmodule

// ===== tb_cpu_registers_address_modes.sv
`timescale 1ns/100ps
// ====
// Random and corner checks of the core.
module tb_cpu_registers_address_modes;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        mem_req, mem_we, mem_ack, irq_req, hp_pin, er;
  logic        irq_acc, hp_acc, stopped;
  logic [7:0]  paddr, mem_wdata, mem_rdata, pb;
  logic [15:0] mem_addr, b, e;
  logic [31:0] pwdata, prdata, rd, seed, q, x, w;
  logic [1:0]  lat, rr;
  logic [15:0] rg [0:3];
  int          miscompares, checks_done, f, n;
  cra_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq_req(irq_req),
    .high_priority_irq_pin(hp_pin), .irq_accept(irq_acc),
    .high_priority_irq_accept(hp_acc), .stopped(stopped));
  cra_mem_model u_mem (.pclk(pclk), .presetn(presetn),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .lat(lat), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  always #5 pclk = ~pclk;
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [15:0] alu(int op, logic [7:0] a, c, m, k);
    logic [8:0] r;
    logic [7:0] t;
    t = k;
    if (op == 0)
      m = c;
    if (op > 4)
      return {k, a};
    r = (op == 3) ? a - m : (op == 4) ? m : a + m + (op == 2 && k[0]);
    if (op < 3)
      t[5] = a[3:0] + m[3:0] + (op == 2 && k[0]) > 15;
    if (op < 4)
      t[0] = r[8];
    t[1] = op < 4 && (a[7] ^ r[7]) && (a[7] ^ m[7]) == (op == 3);
    t[3] = r[7];
    t[2] = r[7:0] == 8'h00;
    return {t, r[7:0]};
  endfunction
  // Returns the new base in the upper half, the address in the lower.
  function logic [31:0] idx(int m, logic [7:0] p, logic [15:0] v, c);
    logic [15:0] d;
    d = p[3] ? {12'hfff, p[3:0]} : p[3:0] + 16'h1;
    case (m)
      2: return {c, 8'h00, p};
      3: return {c, p, v[15:8]};
      4: return {c, c + {{8{p[7]}}, p}};
      5: return {c, c + {p, v[15:8]}};
    endcase
    if (!p[5])
      return {c, c + {{11{p[4]}}, p[4:0]}};
    if (p[7:5] != 3'h7)
      return {c + d, p[4] ? c : c + d};
    case (p[2:0])
      0, 1: return {c, c + {{8{p[0]}}, v[15:8]}};
      2, 3: return {c, c + v};
      4: return {c, c + q[31:24]};
      5: return {c, c + q[23:16]};
      default: return {c, c + q[31:16]};
    endcase
  endfunction
  task complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(string nm, logic [31:0] ex, logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", nm, ex, got);
    end
  endtask
  task apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge pclk);
    chk("ready", 1, pready);
    if (pready !== 1'b1)
      complete_run();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task cmd(logic [31:0] c);
    apb(1, 8'h20, c);
    for (int t = 0; t < 60 && (t == 0 || rd[4] !== 1'b0); t++)
      apb(0, 8'h24, 0);
    chk("busy", 0, rd[4]);
    if (rd[4] !== 1'b0)
      complete_run();
  endtask
  // ====
  // Main sequence.
  initial begin
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, irq_req, hp_pin} = 5'h00;
    paddr = 0;
    pwdata = 0;
    lat = 0;
    seed = 95;
    miscompares = 0;
    checks_done = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 8'h1c, 0);
    chk("ccr", 8'hd0, rd);
    apb(0, 8'h30, 0);
    chk("slverr", 1, er);
    for (int i = 0; i < 24; i++) begin
      q = (i < 6) ? 32'h88888888 : rnd();
      w = 32'hd0 | (rnd() & 32'h2f);
      apb(1, 8'h00, q[31:16]);
      apb(1, 8'h1c, w);
      apb(0, 8'h08, 0);
      chk("acc b", q[23:16], rd);
      cmd({q[15:8], 4'(i % 6), 4'h3});
      chk("err", i % 6 == 5, rd[5]);
      x = alu(i % 6, q[31:24], q[23:16], q[15:8], w[7:0]);
      apb(0, 8'h00, 0);
      chk("acc d", {x[7:0], q[23:16]}, rd);
      apb(0, 8'h1c, 0);
      chk("ccr", x[15:8], rd);
    end
    q = rnd();
    apb(1, 8'h00, q[31:16]);
    for (int k = 0; k < 4; k++) begin
      rg[k] = rnd();
      apb(1, 8'(12 + 4 * k), rg[k]);
    end
    u_mem.mem[rg[3]] = 8'h18;
    cmd(1);
    apb(0, 8'h24, 0);
    chk("page", 8'h44, rd[7:0]);
    for (int i = 0; i < 44; i++) begin
      f = i % 11;
      x = rnd();
      lat <= x[1:0];
      rr = (f == 10) ? 2'(i % 3) : 2'(i % 4);
      pb = f < 4 ? x[23:16] : {rr, f == 10, x[20:16]};
      if (f > 4 && f < 10)
        pb = {3'h7, rr, 3'(f == 5 ? x[16] : f == 6 ? 2 : f == 8 ? 3 : 7)};
      if (f == 7)
        pb[2:0] = 3'(4 + i % 3);
      w = {1'b1, x[30:24], pb, x[15:0]};
      for (int j = 0; j < 4; j++)
        u_mem.mem[16'(rg[3] + j)] = w[31 - 8 * j -: 8];
      b = f < 4 ? rg[3] : rg[rr];
      x = idx(f < 4 ? f + 2 : 6, pb, w[15:0], b);
      e = x[15:0];
      w = rnd();
      if (f == 8 || f == 9) begin
        u_mem.mem[e] = w[15:8];
        u_mem.mem[16'(e + 1)] = w[7:0];
        e = w[15:0];
      end
      cmd(1);
      cmd({24'h0, 4'(f < 4 ? f + 2 : 6), 4'h2});
      chk("err", 0, rd[5]);
      apb(0, 8'h28, 0);
      chk("ea", e, rd);
      apb(0, 8'(12 + 4 * rr), 0);
      chk("base", f < 4 ? rg[rr] : x[31:16], rd);
      rg[rr] = rd[15:0];
    end
    cmd(4);
    b = rg[2] - 16'h2;
    chk("push", rg[3], {u_mem.mem[b], u_mem.mem[16'(b + 1)]});
    apb(0, 8'h14, 0);
    chk("sp", b, rd);
    apb(0, 8'h18, 0);
    chk("pc", e, rd);
    apb(1, 8'h1c, 32'hd0);
    cmd(5);
    chk("stop", 0, stopped);
    apb(1, 8'h1c, 32'h50);
    cmd(5);
    irq_req <= 1'b1;
    hp_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("masked", 3'h4, {stopped, irq_acc, hp_acc});
    apb(1, 8'h1c, 32'h10);
    repeat (2) @(posedge pclk);
    chk("wake", 3'h1, {stopped, irq_acc, hp_acc});
    apb(1, 8'h1c, 32'h00);
    repeat (2) @(posedge pclk);
    chk("irq", 3'h3, {stopped, irq_acc, hp_acc});
    complete_run();
  end
endmodule
